// ### pfm_monitor.sv
// Protection fault monitor: threshold trips with persistence, soft and hard faults, interlock, lock, user I/O alarm.
// Assumes measurements arrive with a one-cycle sample strobe, commands as one-cycle pulses, all synchronous to clk.
`timescale 1ns/100ps
module pfm_monitor
    import pfm_pkg::*;
#(
    parameter int unsigned persist_count = pfm_persist_default,
    parameter int unsigned uio_inputs = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sample_valid,
    input wire pfm_pkg::pfm_meas_type meas,
    input wire logic [uio_inputs-1:0][pfm_pkg::pfm_meas_width-1:0] uio_level,
    input wire logic [1:0] dig_in_level,
    input wire logic thermal_hot,
    input wire pfm_pkg::pfm_cmd_type panel_cmd,
    input wire logic panel_set_valid,
    input wire pfm_pkg::pfm_thresh_type panel_set,
    input wire logic analog_set_valid,
    input wire pfm_pkg::pfm_thresh_type analog_set,
    input wire pfm_pkg::pfm_cmd_type dig_cmd,
    input wire logic dig_lock_level,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic input_switch_on,
    output pfm_pkg::pfm_state_type status,
    output logic [pfm_pkg::pfm_flt_count-1:0] alarm,
    output logic lock_led,
    output logic panel_set_taken
);
    import pfm_pkg::*;

    localparam int unsigned cnt_w = $clog2(persist_count + 1);
    localparam logic [cnt_w-1:0] cnt_max = cnt_w'(persist_count);

    pfm_state_type state;
    pfm_thresh_type thr;
    logic [pfm_flt_count-1:0] faults;
    logic [cnt_w-1:0] cnt_ov, cnt_uv, cnt_oc, cnt_op;
    logic ilk_en, ilk_sel;
    logic lock_dig, lock_sw, lock_panel;
    logic bus_done;
    pfm_cmd_type sw_cmd;
    pfm_cmd_type cmd;
    logic [pfm_flt_count-1:0] cause;
    logic [pfm_flt_count-1:0] persist_hit;
    logic uv_active, ilk_level, locked, bus_wr, clear_ok, thr_wr, soft_new;
    logic [31:0] next_readdata;

    function automatic logic [pfm_meas_width-1:0] clamp_hi(input logic [pfm_meas_width-1:0] v);
        clamp_hi = (v > pfm_trip_limit) ? pfm_trip_limit : v;
    endfunction

    // Zero is kept for under-voltage so software can still disable it
    function automatic logic [pfm_meas_width-1:0] clamp_lo(input logic [pfm_meas_width-1:0] v);
        clamp_lo = (v != '0 && v < pfm_under_min) ? pfm_under_min : v;
    endfunction

    function automatic pfm_thresh_type clamp_all(input pfm_thresh_type t);
        pfm_thresh_type r;
        r.over_voltage_trip = clamp_hi(t.over_voltage_trip);
        r.under_voltage_trip = clamp_lo(t.under_voltage_trip);
        r.over_current_trip = clamp_hi(t.over_current_trip);
        r.over_power_trip = clamp_hi(t.over_power_trip);
        clamp_all = r;
    endfunction

    assign locked = lock_dig | lock_sw | lock_panel;
    assign bus_wr = avs_write & ~bus_done;
    assign thr_wr = bus_wr && (avs_address inside {pfm_addr_over_voltage_trip, pfm_addr_under_voltage_trip,
        pfm_addr_over_current_trip, pfm_addr_over_power_trip});
    assign uv_active = (thr.under_voltage_trip != '0);
    assign ilk_level = ilk_sel ? dig_in_level[1] : dig_in_level[0];

    // Panel start and clear masked while locked; stop is always honoured
    always_comb begin
        cmd.start = (panel_cmd.start & ~locked) | dig_cmd.start | sw_cmd.start;
        cmd.stop = panel_cmd.stop | dig_cmd.stop | sw_cmd.stop;
        cmd.clear = (panel_cmd.clear & ~locked) | dig_cmd.clear | sw_cmd.clear;
        cmd.lock = 1'b0;
        cmd.unlock = 1'b0;
    end

    always_comb begin
        sw_cmd = '0;
        if (bus_wr && avs_address == pfm_addr_ctrl && avs_byteenable[0]) begin
            sw_cmd.start = avs_writedata[pfm_ctrl_start];
            sw_cmd.stop = avs_writedata[pfm_ctrl_stop];
            sw_cmd.clear = avs_writedata[pfm_ctrl_clear];
            sw_cmd.lock = avs_writedata[pfm_ctrl_lock];
            sw_cmd.unlock = avs_writedata[pfm_ctrl_unlock];
        end
    end

    // Live causes; a fault other than under-voltage cannot be cleared while its cause stands
    always_comb begin
        cause = '0;
        cause[pfm_flt_ov] = meas.voltage > thr.over_voltage_trip;
        cause[pfm_flt_uv] = uv_active && meas.voltage <= thr.under_voltage_trip;
        cause[pfm_flt_oc] = meas.current > thr.over_current_trip;
        cause[pfm_flt_op] = meas.power > thr.over_power_trip;
        cause[pfm_flt_ilk] = ilk_en & ~ilk_level;
        cause[pfm_flt_therm] = thermal_hot;
        for (int i = 0; i < uio_inputs; i++) begin
            if (uio_level[i] > ((i < uio_inputs / 2) ? pfm_uio_dig_alarm : pfm_uio_ana_alarm)) begin
                cause[pfm_flt_uio] = 1'b1;
            end
        end
    end

    // Under-voltage recovery needs no voltage condition, so it is left out of the check
    assign clear_ok = ~|(faults & cause & ~(pfm_flt_count'(1) << pfm_flt_uv));

    // Gated by the live cause, so a count left standing after the level drops cannot re-latch
    assign persist_hit[pfm_flt_ov] = cause[pfm_flt_ov] && (cnt_ov == cnt_max);
    assign persist_hit[pfm_flt_uv] = cause[pfm_flt_uv] && (cnt_uv == cnt_max);
    assign persist_hit[pfm_flt_oc] = cause[pfm_flt_oc] && (cnt_oc == cnt_max);
    assign persist_hit[pfm_flt_op] = cause[pfm_flt_op] && (cnt_op == cnt_max);
    assign soft_new = |(persist_hit & ~faults & ~(pfm_flt_count'(1) << pfm_flt_uv));
    assign persist_hit[pfm_flt_ilk] = cause[pfm_flt_ilk];
    assign persist_hit[pfm_flt_uio] = cause[pfm_flt_uio];
    assign persist_hit[pfm_flt_therm] = cause[pfm_flt_therm];

    // Counters saturate and restart on any good sample, so a glitch never trips
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_ov <= '0;
            cnt_uv <= '0;
            cnt_oc <= '0;
            cnt_op <= '0;
        end else if (sample_valid) begin
            cnt_ov <= !cause[pfm_flt_ov] ? '0 : (persist_hit[pfm_flt_ov] ? cnt_ov : cnt_ov + 1'b1);
            cnt_uv <= !cause[pfm_flt_uv] ? '0 : (persist_hit[pfm_flt_uv] ? cnt_uv : cnt_uv + 1'b1);
            cnt_oc <= !cause[pfm_flt_oc] ? '0 : (persist_hit[pfm_flt_oc] ? cnt_oc : cnt_oc + 1'b1);
            cnt_op <= !cause[pfm_flt_op] ? '0 : (persist_hit[pfm_flt_op] ? cnt_op : cnt_op + 1'b1);
        end
    end

    // Thresholds: the bus wins over panel and analog sources in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            thr.over_voltage_trip <= pfm_over_default;
            thr.under_voltage_trip <= pfm_under_default;
            thr.over_current_trip <= pfm_current_default;
            thr.over_power_trip <= pfm_power_default;
        end else if (bus_wr && avs_address == pfm_addr_over_voltage_trip) begin
            thr.over_voltage_trip <= clamp_hi(avs_writedata[pfm_meas_width-1:0]);
        end else if (bus_wr && avs_address == pfm_addr_under_voltage_trip) begin
            thr.under_voltage_trip <= clamp_lo(avs_writedata[pfm_meas_width-1:0]);
        end else if (bus_wr && avs_address == pfm_addr_over_current_trip) begin
            thr.over_current_trip <= clamp_hi(avs_writedata[pfm_meas_width-1:0]);
        end else if (bus_wr && avs_address == pfm_addr_over_power_trip) begin
            thr.over_power_trip <= clamp_hi(avs_writedata[pfm_meas_width-1:0]);
        end else if (panel_set_valid && !locked) begin
            thr <= clamp_all(panel_set);
        end else if (analog_set_valid) begin
            thr <= clamp_all(analog_set);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            panel_set_taken <= 1'b0;
        end else begin
            panel_set_taken <= panel_set_valid & ~locked & ~thr_wr;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ilk_en <= 1'b0;
            ilk_sel <= 1'b0;
        end else if (bus_wr && avs_address == pfm_addr_config && avs_byteenable[0]) begin
            ilk_en <= avs_writedata[pfm_cfg_ilk_en];
            ilk_sel <= avs_writedata[pfm_cfg_ilk_sel];
        end
    end

    // Lock sources kept apart so each can only be released by its owners
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lock_dig <= 1'b0;
            lock_sw <= 1'b0;
            lock_panel <= 1'b0;
        end else begin
            lock_dig <= dig_lock_level;
            if (!lock_dig) begin
                if (sw_cmd.lock) begin
                    lock_sw <= 1'b1;
                end else if (sw_cmd.unlock) begin
                    lock_sw <= 1'b0;
                    lock_panel <= 1'b0;
                end
                if (!lock_sw && panel_cmd.lock && !lock_panel) begin
                    lock_panel <= 1'b1;
                end else if (!lock_sw && panel_cmd.unlock && lock_panel) begin
                    lock_panel <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lock_led <= 1'b0;
        end else begin
            lock_led <= dig_lock_level | (lock_sw & ~sw_cmd.unlock) | lock_panel | (sw_cmd.lock & ~lock_dig);
        end
    end

    // Fault latches: a new event beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            faults <= '0;
        end else begin
            for (int i = 0; i < pfm_flt_count; i++) begin
                if (i == pfm_flt_therm) begin
                    if (cause[i]) begin
                        faults[i] <= 1'b1;
                    end
                end else if (persist_hit[i] && (state == pfm_st_enabled ||
                                                (state == pfm_st_soft && i != pfm_flt_uv))) begin
                    faults[i] <= 1'b1;
                end else if (state == pfm_st_enabled && cmd.start == 1'b0 && i == pfm_flt_uv && cause[i]) begin
                    faults[i] <= faults[i];
                end else if (state == pfm_st_disabled && cmd.start && i == pfm_flt_uv && cause[i]) begin
                    faults[i] <= 1'b1;
                end else if (state == pfm_st_soft && cmd.clear && clear_ok) begin
                    faults[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= pfm_st_disabled;
        end else begin
            case (state)
                pfm_st_disabled: begin
                    if (cause[pfm_flt_therm]) begin
                        state <= pfm_st_hard;
                    end else if (cmd.start && uv_active && cause[pfm_flt_uv]) begin
                        state <= pfm_st_soft;
                    end else if (cmd.start && !cmd.stop) begin
                        state <= pfm_st_enabled;
                    end
                end
                pfm_st_enabled: begin
                    if (cause[pfm_flt_therm]) begin
                        state <= pfm_st_hard;
                    end else if (|(persist_hit & ~(pfm_flt_count'(1) << pfm_flt_therm))) begin
                        state <= pfm_st_soft;
                    end else if (cmd.stop) begin
                        state <= pfm_st_disabled;
                    end
                end
                pfm_st_soft: begin
                    if (cause[pfm_flt_therm]) begin
                        state <= pfm_st_hard;
                    end else if (cmd.clear && clear_ok && !soft_new) begin
                        state <= pfm_st_disabled;
                    end
                end
                pfm_st_hard: begin
                    state <= pfm_st_hard;
                end
                default: begin
                    state <= pfm_st_hard;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            input_switch_on <= 1'b0;
            status <= pfm_st_disabled;
            alarm <= '0;
        end else begin
            // Switch follows the next state so a trip opens it in the same edge as the latch
            input_switch_on <= (state == pfm_st_enabled && !cmd.stop && !(|persist_hit)) ||
                               (state == pfm_st_disabled && cmd.start && !cmd.stop && !(|cause[pfm_flt_therm])
                                && !(uv_active && cause[pfm_flt_uv]));
            status <= state;
            alarm <= faults;
        end
    end

    // Avalon slave: one wait cycle, answer on the second edge; unmapped reads give zero
    always_comb begin
        next_readdata = '0;
        case (avs_address)
            pfm_addr_status: next_readdata = {28'h0000000, state};
            pfm_addr_over_voltage_trip: next_readdata = {16'h0000, thr.over_voltage_trip};
            pfm_addr_under_voltage_trip: next_readdata = {16'h0000, thr.under_voltage_trip};
            pfm_addr_over_current_trip: next_readdata = {16'h0000, thr.over_current_trip};
            pfm_addr_over_power_trip: next_readdata = {16'h0000, thr.over_power_trip};
            pfm_addr_config: next_readdata = {30'h0, ilk_sel, ilk_en};
            pfm_addr_faults: next_readdata = {22'h0, locked, lock_dig, lock_sw, faults};
            default: next_readdata = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_done <= 1'b0;
            avs_readdata <= '0;
        end else begin
            bus_done <= (avs_read | avs_write) & ~bus_done;
            if (avs_read && !bus_done) begin
                avs_readdata <= next_readdata;
            end
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~bus_done;
endmodule

// ### pfm_monitor_props.sv
// Port checker for the protection fault monitor.
// Assumes one clock and the synchronous active-high reset of the monitor.
`timescale 1ns/100ps
module pfm_monitor_props
    import pfm_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic thermal_hot,
    input wire logic panel_set_valid,
    input wire logic dig_lock_level,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic input_switch_on,
    input wire pfm_pkg::pfm_state_type status,
    input wire logic [pfm_pkg::pfm_flt_count-1:0] alarm,
    input wire logic lock_led,
    input wire logic panel_set_taken
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("bus request answered without its wait state");
    a_wait_one: assert property (avs_waitrequest |=> !avs_waitrequest)
        else $error("bus wait state longer than one cycle");
    a_soft_open: assert property (status == pfm_st_soft |-> !input_switch_on)
        else $error("switch closed in soft fault");
    a_hard_open: assert property (status == pfm_st_hard |-> !input_switch_on)
        else $error("switch closed in hard fault");
    a_therm_hard: assert property (thermal_hot && !sys_rst |-> ##2 status == pfm_st_hard)
        else $error("hot heatsink did not give hard fault");
    a_hard_kept: assert property (status == pfm_st_hard && !sys_rst |=> status == pfm_st_hard)
        else $error("hard fault left without reset");
    a_therm_alarm: assert property (alarm[pfm_flt_therm] |-> status == pfm_st_hard)
        else $error("thermal alarm outside hard fault");
    a_start_origin: assert property ($rose(input_switch_on) |-> status == pfm_st_disabled)
        else $error("switch closed from a state other than disabled");
    a_enabled_on: assert property (status == pfm_st_enabled |-> $past(input_switch_on))
        else $error("enabled status without closed switch");
    a_dig_lock: assert property (dig_lock_level [*2] |-> lock_led)
        else $error("digital lock not shown on lock indicator");
    a_set_cause: assert property (panel_set_taken |-> $past(panel_set_valid))
        else $error("panel set taken without a request");
endmodule
bind pfm_monitor pfm_monitor_props u_props (.clk(clk), .sys_rst(sys_rst), .thermal_hot(thermal_hot),
    .panel_set_valid(panel_set_valid), .dig_lock_level(dig_lock_level), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .input_switch_on(input_switch_on),
    .status(status), .alarm(alarm), .lock_led(lock_led), .panel_set_taken(panel_set_taken));

// ### pfm_monitor_test.sv
// Self-checking bench for the protection fault monitor.
// Assumes the package, the monitor, its checker and the source model are compiled first.
`timescale 1ns/100ps
module pfm_monitor_test;
    import pfm_pkg::*;
    logic clk, sys_rst, sample_valid, thermal_hot, panel_set_valid, analog_set_valid, dig_lock_level;
    logic avs_read, avs_write, avs_waitrequest, input_switch_on, lock_led, panel_set_taken;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [1:0] dig_in_level;
    logic [pfm_flt_count-1:0] alarm;
    pfm_meas_type meas, level;
    pfm_cmd_type panel_cmd;
    pfm_thresh_type panel_set, analog_set;
    pfm_state_type status;
    int err_count, check_count, cycles;
    pfm_source src (.clk(clk), .sys_rst(sys_rst), .level(level), .sample_valid(sample_valid), .meas(meas));
    pfm_monitor #(.persist_count(2), .uio_inputs(8)) dut (.clk(clk), .sys_rst(sys_rst),
        .sample_valid(sample_valid), .meas(meas), .uio_level('0), .dig_in_level(dig_in_level),
        .thermal_hot(thermal_hot), .panel_cmd(panel_cmd), .panel_set_valid(panel_set_valid),
        .panel_set(panel_set), .analog_set_valid(analog_set_valid), .analog_set(analog_set), .dig_cmd('0),
        .dig_lock_level(dig_lock_level), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .input_switch_on(input_switch_on), .status(status),
        .alarm(alarm), .lock_led(lock_led), .panel_set_taken(panel_set_taken));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    // Held until waitrequest is sampled low at a rising edge; read data is taken at that edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Command bits: 10 start, 08 stop, 04 clear, 02 lock, 01 unlock
    task automatic cmd(input pfm_cmd_type c);
        @(posedge clk);
        panel_cmd <= c;
        @(posedge clk);
        panel_cmd <= '0;
        settle(16);
    endtask
    task automatic state_is(input pfm_state_type s, input logic sw);
        chk("status", 32'(s), 32'(status));
        chk("switch", 32'(sw), 32'(input_switch_on));
    endtask
    task automatic t_regs();
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 6'h08 + 6'(4 * i), 32'h0);
            chk("threshold reset", (i == 1) ? 32'h0 : 32'hd333, rd);
            bus(1'b1, 6'h08 + 6'(4 * i), (i == 1) ? 32'h1 : 32'hffff);
            bus(1'b0, 6'h08 + 6'(4 * i), 32'h0);
            chk("threshold clamp", (i == 1) ? 32'h099a : 32'hd333, rd);
        end
        bus(1'b1, 6'h0c, 32'h0);
        bus(1'b0, 6'h3c, 32'h0);
        chk("unmapped read", 32'h0, rd);
        state_is(pfm_st_disabled, 1'b0);
    endtask
    task automatic t_trip(input int k, input int flt);
        logic [47:0] hi;
        hi = 48'h9000 << (16 * (2 - k));
        bus(1'b1, 6'h08 + 6'(4 * flt), 32'h8000);
        level <= 48'h0;
        cmd(5'h10);
        state_is(pfm_st_enabled, 1'b1);
        level <= hi;
        repeat (3) @(posedge clk);
        level <= 48'h0;
        settle(16);
        state_is(pfm_st_enabled, 1'b1);
        level <= hi;
        settle(24);
        state_is(pfm_st_soft, 1'b0);
        chk("alarm", 32'(1 << flt), 32'(alarm));
        cmd(5'h04);
        state_is(pfm_st_soft, 1'b0);
        level <= 48'h0;
        cmd(5'h04);
        state_is(pfm_st_disabled, 1'b0);
        cmd(5'h10);
        state_is(pfm_st_enabled, 1'b1);
        cmd(5'h08);
    endtask
    task automatic t_under();
        @(posedge clk);
        analog_set <= '{16'hd333, 16'h2000, 16'hd333, 16'hd333};
        analog_set_valid <= 1'b1;
        @(posedge clk);
        analog_set_valid <= 1'b0;
        level <= 48'h1000_0000_0000;
        cmd(5'h10);
        state_is(pfm_st_soft, 1'b0);
        chk("alarm", 32'h2, 32'(alarm));
        cmd(5'h04);
        state_is(pfm_st_disabled, 1'b0);
        bus(1'b0, 6'h0c, 32'h0);
        chk("analog set", 32'h2000, rd);
        @(posedge clk);
        panel_set <= '{16'hd333, 16'h0, 16'hd333, 16'hd333};
        panel_set_valid <= 1'b1;
        @(posedge clk);
        panel_set_valid <= 1'b0;
        @(negedge clk);
        chk("panel set taken", 32'h1, 32'(panel_set_taken));
        cmd(5'h10);
        state_is(pfm_st_enabled, 1'b1);
        cmd(5'h08);
    endtask
    task automatic t_interlock();
        @(posedge clk);
        dig_in_level <= 2'b11;
        bus(1'b1, 6'h18, 32'h1);
        cmd(5'h10);
        @(posedge clk);
        dig_in_level <= 2'b10;
        settle(4);
        state_is(pfm_st_soft, 1'b0);
        chk("alarm", 32'h10, 32'(alarm));
        cmd(5'h04);
        state_is(pfm_st_soft, 1'b0);
        @(posedge clk);
        dig_in_level <= 2'b11;
        cmd(5'h04);
        state_is(pfm_st_disabled, 1'b0);
        bus(1'b1, 6'h18, 32'h0);
    endtask
    task automatic t_lock();
        cmd(5'h10);
        cmd(5'h02);
        chk("lock led", 32'h1, 32'(lock_led));
        cmd(5'h08);
        state_is(pfm_st_disabled, 1'b0);
        cmd(5'h10);
        state_is(pfm_st_disabled, 1'b0);
        bus(1'b1, 6'h00, 32'h10);
        settle(2);
        chk("lock led", 32'h0, 32'(lock_led));
        bus(1'b1, 6'h00, 32'h08);
        cmd(5'h01);
        chk("lock led", 32'h1, 32'(lock_led));
        bus(1'b1, 6'h00, 32'h10);
        @(posedge clk);
        dig_lock_level <= 1'b1;
        cmd(5'h01);
        bus(1'b1, 6'h00, 32'h10);
        settle(2);
        chk("lock led", 32'h1, 32'(lock_led));
        @(posedge clk);
        dig_lock_level <= 1'b0;
        settle(2);
        chk("lock led", 32'h0, 32'(lock_led));
    endtask
    task automatic t_thermal();
        @(posedge clk);
        thermal_hot <= 1'b1;
        settle(4);
        state_is(pfm_st_hard, 1'b0);
        chk("alarm", 32'h40, 32'(alarm));
        cmd(5'h04);
        cmd(5'h10);
        state_is(pfm_st_hard, 1'b0);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            sys_rst <= 1'b1;
            @(posedge clk);
            sys_rst <= 1'b0;
            thermal_hot <= (i == 0);
            settle(4);
            state_is(i == 0 ? pfm_st_hard : pfm_st_disabled, 1'b0);
        end
    endtask
    initial begin
        err_count = 0;
        check_count = 0;
        cycles = 0;
        sys_rst = 1'b1;
        thermal_hot = 1'b0;
        panel_set_valid = 1'b0;
        analog_set_valid = 1'b0;
        dig_lock_level = 1'b0;
        dig_in_level = 2'b00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 6'h00;
        avs_writedata = 32'h0;
        level = '0;
        panel_cmd = '0;
        panel_set = '0;
        analog_set = '0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_trip(0, pfm_flt_ov);
        t_trip(1, pfm_flt_oc);
        t_trip(2, pfm_flt_op);
        t_under();
        t_interlock();
        t_lock();
        t_thermal();
        finish_test();
    end
endmodule

// ### pfm_pkg.sv
// Package for the protection fault monitor: Avalon register map, field layout, reset values, status codes.
// Assumes a 32-bit Avalon-MM slave with word addressing in bytes and a single 250 MHz clock.
package pfm_pkg;
    localparam int unsigned pfm_clk_mhz = 250;
    localparam int unsigned pfm_meas_width = 16;
    localparam logic [pfm_meas_width-1:0] pfm_full_scale = 16'hc000;
    localparam logic [pfm_meas_width-1:0] pfm_trip_limit = 16'hd333;
    localparam logic [pfm_meas_width-1:0] pfm_under_min = 16'h099a;
    localparam logic [pfm_meas_width-1:0] pfm_over_default = 16'hd333;
    localparam logic [pfm_meas_width-1:0] pfm_under_default = 16'h0000;
    localparam logic [pfm_meas_width-1:0] pfm_current_default = 16'hd333;
    localparam logic [pfm_meas_width-1:0] pfm_power_default = 16'hd333;
    localparam logic [pfm_meas_width-1:0] pfm_uio_dig_alarm = 16'h8ccd;
    localparam logic [pfm_meas_width-1:0] pfm_uio_ana_alarm = 16'h8ccd;
    localparam int unsigned pfm_persist_default = 4;

    localparam logic [5:0] pfm_addr_ctrl = 6'h00;
    localparam logic [5:0] pfm_addr_status = 6'h04;
    localparam logic [5:0] pfm_addr_over_voltage_trip = 6'h08;
    localparam logic [5:0] pfm_addr_under_voltage_trip = 6'h0c;
    localparam logic [5:0] pfm_addr_over_current_trip = 6'h10;
    localparam logic [5:0] pfm_addr_over_power_trip = 6'h14;
    localparam logic [5:0] pfm_addr_config = 6'h18;
    localparam logic [5:0] pfm_addr_faults = 6'h1c;

    localparam int unsigned pfm_ctrl_start = 0;
    localparam int unsigned pfm_ctrl_stop = 1;
    localparam int unsigned pfm_ctrl_clear = 2;
    localparam int unsigned pfm_ctrl_lock = 3;
    localparam int unsigned pfm_ctrl_unlock = 4;
    localparam int unsigned pfm_cfg_ilk_en = 0;
    localparam int unsigned pfm_cfg_ilk_sel = 1;

    localparam int unsigned pfm_flt_ov = 0;
    localparam int unsigned pfm_flt_uv = 1;
    localparam int unsigned pfm_flt_oc = 2;
    localparam int unsigned pfm_flt_op = 3;
    localparam int unsigned pfm_flt_ilk = 4;
    localparam int unsigned pfm_flt_uio = 5;
    localparam int unsigned pfm_flt_therm = 6;
    localparam int unsigned pfm_flt_count = 7;

    typedef enum logic [3:0] {
        pfm_st_disabled = 4'b0001,
        pfm_st_enabled = 4'b0010,
        pfm_st_soft = 4'b0100,
        pfm_st_hard = 4'b1000
    } pfm_state_type;

    typedef struct packed {
        logic [pfm_meas_width-1:0] voltage;
        logic [pfm_meas_width-1:0] current;
        logic [pfm_meas_width-1:0] power;
    } pfm_meas_type;

    typedef struct packed {
        logic start;
        logic stop;
        logic clear;
        logic lock;
        logic unlock;
    } pfm_cmd_type;

    typedef struct packed {
        logic [pfm_meas_width-1:0] over_voltage_trip;
        logic [pfm_meas_width-1:0] under_voltage_trip;
        logic [pfm_meas_width-1:0] over_current_trip;
        logic [pfm_meas_width-1:0] over_power_trip;
    } pfm_thresh_type;
endpackage

// ### pfm_source.sv
// Sensing front-end model: presents the bench's levels with a sample strobe every fourth cycle.
// Assumes the monitor's clock and reset.
`timescale 1ns/100ps
module pfm_source
    import pfm_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire pfm_pkg::pfm_meas_type level,
    output logic sample_valid,
    output pfm_pkg::pfm_meas_type meas
);
    logic [1:0] phase;
    // Spaced strobes, so a short excursion spans one sample at most
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase <= 2'h0;
            sample_valid <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            sample_valid <= (phase == 2'h3);
        end
    end
    always_ff @(posedge clk) begin
        meas <= level;
    end
endmodule
